// ### logic/ffsup_regs.svh
`ifndef FFSUP_REGS_SVH
`define FFSUP_REGS_SVH
// ****************************************************************
// register map
// ****************************************************************
`define FFSUP_ADDR_CTRL       8'h00
`define FFSUP_ADDR_STATUS     8'h04
`define FFSUP_ADDR_CAUSE      8'h08
`define FFSUP_CTRL_RESET      32'h0000_0000
`define FFSUP_CTRL_OVP_LATCH  0
`define FFSUP_CTRL_SD_LATCH   1
`define FFSUP_CTRL_UVP_LONG   2
`define FFSUP_CTRL_CLR        3
// ****************************************************************
// timing
// ****************************************************************
`define FFSUP_CLK_MHZ         25
`define FFSUP_VDD_OVP_US      10
`define FFSUP_BRO_US          40
`define FFSUP_SD_US           10
`define FFSUP_OLP_MS          50
`define FFSUP_LAR_MS          100
`define FFSUP_AR_US           1000
`define FFSUP_UVP_BNK_MS      20
`define FFSUP_CSSP_DB_NS      200
`define FFSUP_RECTIFIER_SHORT_GUARD_BNK_NS     120
`define FFSUP_VDD_OVP_CYC     (`FFSUP_VDD_OVP_US * `FFSUP_CLK_MHZ)
`define FFSUP_BRO_CYC         (`FFSUP_BRO_US * `FFSUP_CLK_MHZ)
`define FFSUP_SD_CYC          (`FFSUP_SD_US * `FFSUP_CLK_MHZ)
`define FFSUP_OLP_CYC         (`FFSUP_OLP_MS * 1000 * `FFSUP_CLK_MHZ)
`define FFSUP_LAR_CYC         (`FFSUP_LAR_MS * 1000 * `FFSUP_CLK_MHZ)
`define FFSUP_AR_CYC          (`FFSUP_AR_US * `FFSUP_CLK_MHZ)
`define FFSUP_UVP_BNK_CYC     (`FFSUP_UVP_BNK_MS * 1000 * `FFSUP_CLK_MHZ)
`define FFSUP_CSSP_DB_CYC     ((`FFSUP_CSSP_DB_NS * `FFSUP_CLK_MHZ + 999) / 1000)
`define FFSUP_RECTIFIER_SHORT_GUARD_BNK_CYC    ((`FFSUP_RECTIFIER_SHORT_GUARD_BNK_NS * `FFSUP_CLK_MHZ + 999) / 1000)
`define FFSUP_CSSP_TON_CYC    4
`define FFSUP_BRI_CNT         4
`define FFSUP_OVP_CNT         3
`define FFSUP_UVP_CNT         8
`define FFSUP_CSSP_CNT        4
`define FFSUP_RECTIFIER_SHORT_GUARD_CNT        4
`endif

// ### logic/ffsup_pkg.sv
`default_nettype none
package ffsup_pkg;
	typedef enum logic [2:0] {
		FFSUP_OFF, FFSUP_RUN, FFSUP_AR, FFSUP_LAR, FFSUP_LATCH
	} ffsup_state_e;

	typedef struct packed {
		logic vdd_ovp;
		logic line_above_bri;
		logic line_below_bro;
		logic over_temp;
		logic output_sense_overvoltage;
		logic output_sense_undervoltage;
		logic shutdown_low;
		logic cs_below_cssp;
		logic cs_above_rectifier_short_guard;
		logic feedback_above_olp;
		logic cs_above_limit;
	} ffsup_cmp_s;

	typedef logic [10:0] ffsup_cause_t;
endpackage : ffsup_pkg
`default_nettype wire

// ### logic/ffsup_top.sv
// Functional notes
// R01 - vdd overvoltage held debounce time: auto-restart
// R02 - brown-in after consecutive conducting cycles above
// R03 - line below brown-out too long: stop
// R04 - over-temperature disables pulses, protection mode
// R05 - output overvoltage cycles: auto-restart or latch
// R06 - output undervoltage cycles: restart or long
// R07 - undervoltage ignored during start-up blanking
// R08 - start-up shutdown threshold, then normal
// R09 - shutdown pin low debounce: trigger
// R10 - shutdown trigger: auto-restart or latch
// R11 - sense short after debounce: limit on-time
// R12 - sense short cycles persist: auto-restart
// R13 - after blanking, rectifier short ends pulse
// R14 - rectifier short cycles recur: auto-restart
// R15 - feedback at overload level starts timer
// R16 - overload timer expiry: auto-restart
// R17 - feedback drop clears overload timer
// R18 - peak current limit ends pulse
// R19 - long restart interval, then supply check
// R20 - no brown-in at start: auto-restart
// R21 - latch holds until supply reset
// R22 - inputs synchronised, counters restart on release
`timescale 1ns/1ns
`default_nettype none
`include "ffsup_regs.svh"
module ffsup_top
	import ffsup_pkg::*;
#(
	parameter int OLP_CYC     = `FFSUP_OLP_CYC,
	parameter int LAR_CYC     = `FFSUP_LAR_CYC,
	parameter int UVP_BNK_CYC = `FFSUP_UVP_BNK_CYC,
	parameter int AR_CYC      = `FFSUP_AR_CYC,
	parameter int brownin_debounce_count = `FFSUP_BRI_CNT
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire ffsup_cmp_s  cmp_in,
	input  wire logic        vdd_on,
	input  wire logic        gate_req,
	output logic             gate_drive,
	output logic             sd_startup_level,
	output logic             switching_en
);
	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic logic [31:0] bump(input logic [31:0] v, input logic cond);
		bump = cond ? ((v == 32'hFFFF_FFFF) ? v : v + 32'h0000_0001) : 32'h0000_0000;
	endfunction : bump

	// ****************************************************************
	// input synchroniser
	// ****************************************************************
	ffsup_cmp_s cmp_m;
	ffsup_cmp_s cmp;
	logic       vdd_m;
	logic       vdd_s;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cmp_m <= '0;
			cmp   <= '0;
			vdd_m <= 1'b0;
			vdd_s <= 1'b0;
		end else begin
			cmp_m <= cmp_in; // [R22]
			cmp   <= cmp_m;
			vdd_m <= vdd_on;
			vdd_s <= vdd_m;
		end
	end

	// ****************************************************************
	// switching cycle edges
	// ****************************************************************
	ffsup_state_e state;
	logic         req_d;
	logic         pulse_on;
	logic [31:0]  on_cnt;
	logic         cyc_end;
	logic         kill_now;
	logic         cssp_seen;
	logic         rectifier_short_guard_seen;
	logic         ovp_seen;
	logic         uvp_seen;
	logic         bri_seen;
	assign cyc_end = req_d && !gate_req;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			req_d  <= 1'b0;
			on_cnt <= 32'h0000_0000;
		end else begin
			req_d  <= gate_req;
			on_cnt <= bump(on_cnt, gate_req);
		end
	end

	// ****************************************************************
	// per-pulse termination
	// ****************************************************************
	always_comb begin
		kill_now = cmp.cs_above_limit; // [R18]
		if (on_cnt >= `FFSUP_RECTIFIER_SHORT_GUARD_BNK_CYC && cmp.cs_above_rectifier_short_guard)
			kill_now = 1'b1; // [R13]
		if (on_cnt >= `FFSUP_CSSP_DB_CYC + `FFSUP_CSSP_TON_CYC && cmp.cs_below_cssp)
			kill_now = 1'b1; // [R11]
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			pulse_on <= 1'b0;
		else if (!gate_req || state != FFSUP_RUN || cmp.over_temp) // [R04]
			pulse_on <= 1'b0;
		else if (!req_d)
			pulse_on <= 1'b1;
		else if (kill_now)
			pulse_on <= 1'b0;
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			gate_drive <= 1'b0;
		else
			gate_drive <= pulse_on && gate_req && !kill_now && !cmp.over_temp;
	end

	// ****************************************************************
	// per-cycle observations
	// ****************************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cssp_seen <= 1'b0;
			rectifier_short_guard_seen <= 1'b0;
			ovp_seen  <= 1'b0;
			uvp_seen  <= 1'b0;
			bri_seen  <= 1'b0;
		end else if (cyc_end) begin
			cssp_seen <= 1'b0;
			rectifier_short_guard_seen <= 1'b0;
			ovp_seen  <= 1'b0;
			uvp_seen  <= 1'b0;
			bri_seen  <= 1'b0;
		end else begin
			if (gate_req && on_cnt >= `FFSUP_CSSP_DB_CYC && cmp.cs_below_cssp)
				cssp_seen <= 1'b1;
			if (gate_req && on_cnt >= `FFSUP_RECTIFIER_SHORT_GUARD_BNK_CYC && cmp.cs_above_rectifier_short_guard)
				rectifier_short_guard_seen <= 1'b1;
			if (!gate_req && cmp.output_sense_overvoltage)
				ovp_seen <= 1'b1;
			if (!gate_req && cmp.output_sense_undervoltage)
				uvp_seen <= 1'b1;
			if (gate_req && cmp.line_above_bri)
				bri_seen <= 1'b1; // [R02]
		end
	end

	// ****************************************************************
	// cycle counters
	// ****************************************************************
	logic [7:0] n_bri;
	logic [7:0] n_ovp;
	logic [7:0] n_uvp;
	logic [7:0] n_cssp;
	logic [7:0] n_rectifier_short_guard;
	logic       brownin;
	logic       uvp_blank;
	logic [31:0] bnk_cnt;
	function automatic logic [7:0] ccount(input logic [7:0] v, input logic hit);
		ccount = hit ? ((v == 8'hFF) ? v : v + 8'h01) : 8'h00;
	endfunction : ccount
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			n_bri  <= 8'h00;
			n_ovp  <= 8'h00;
			n_uvp  <= 8'h00;
			n_cssp <= 8'h00;
			n_rectifier_short_guard <= 8'h00;
		end else if (state != FFSUP_RUN) begin
			n_bri  <= 8'h00;
			n_ovp  <= 8'h00;
			n_uvp  <= 8'h00;
			n_cssp <= 8'h00;
			n_rectifier_short_guard <= 8'h00;
		end else if (cyc_end) begin
			n_bri  <= ccount(n_bri, bri_seen); // [R02] [R22]
			n_ovp  <= ccount(n_ovp, ovp_seen); // [R05]
			n_uvp  <= ccount(n_uvp, uvp_seen && !uvp_blank); // [R07]
			n_cssp <= ccount(n_cssp, cssp_seen); // [R12]
			n_rectifier_short_guard <= ccount(n_rectifier_short_guard, rectifier_short_guard_seen); // [R14]
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			brownin <= 1'b0;
		else if (state != FFSUP_RUN)
			brownin <= 1'b0;
		else if (n_bri >= 8'(brownin_debounce_count))
			brownin <= 1'b1; // [R02]
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			bnk_cnt <= 32'h0000_0000;
		else if (state != FFSUP_RUN)
			bnk_cnt <= 32'h0000_0000;
		else
			bnk_cnt <= bump(bnk_cnt, 1'b1);
	end
	assign uvp_blank = bnk_cnt < 32'(UVP_BNK_CYC); // [R07]

	// ****************************************************************
	// time debounce
	// ****************************************************************
	logic [31:0] t_ovp;
	logic [31:0] t_bro;
	logic [31:0] t_sd;
	logic [31:0] t_olp;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			t_ovp <= 32'h0000_0000;
			t_bro <= 32'h0000_0000;
			t_sd  <= 32'h0000_0000;
			t_olp <= 32'h0000_0000;
		end else begin
			t_ovp <= bump(t_ovp, cmp.vdd_ovp); // [R01] [R22]
			t_bro <= bump(t_bro, cmp.line_below_bro && brownin); // [R03]
			t_sd  <= bump(t_sd, cmp.shutdown_low); // [R09]
			t_olp <= bump(t_olp, cmp.feedback_above_olp); // [R15] [R17]
		end
	end

	// ****************************************************************
	// fault decision
	// ****************************************************************
	ffsup_cause_t cause;
	ffsup_cause_t next_cause;
	logic [31:0]  ctrl;
	logic         f_ar;
	logic         f_lar;
	logic         f_latch;
	logic         no_brownin;
	assign no_brownin = bnk_cnt >= 32'(UVP_BNK_CYC) && !brownin;
	always_comb begin
		next_cause    = '0;
		next_cause[0] = t_ovp > 32'(`FFSUP_VDD_OVP_CYC); // [R01]
		next_cause[1] = t_bro > 32'(`FFSUP_BRO_CYC); // [R03]
		next_cause[2] = cmp.over_temp; // [R04]
		next_cause[3] = n_ovp > 8'(`FFSUP_OVP_CNT); // [R05]
		next_cause[4] = n_uvp > 8'(`FFSUP_UVP_CNT); // [R06]
		next_cause[5] = t_sd >= 32'(`FFSUP_SD_CYC); // [R09]
		next_cause[6] = n_cssp >= 8'(`FFSUP_CSSP_CNT); // [R12]
		next_cause[7] = n_rectifier_short_guard >= 8'(`FFSUP_RECTIFIER_SHORT_GUARD_CNT); // [R14]
		next_cause[8] = t_olp > 32'(OLP_CYC); // [R16]
		next_cause[9] = no_brownin; // [R20]
		f_latch = (next_cause[3] && ctrl[`FFSUP_CTRL_OVP_LATCH])
			|| (next_cause[5] && ctrl[`FFSUP_CTRL_SD_LATCH]); // [R05] [R10]
		f_lar   = next_cause[4] && ctrl[`FFSUP_CTRL_UVP_LONG]; // [R06]
		f_ar    = |next_cause;
	end

	// ****************************************************************
	// protection state machine
	// ****************************************************************
	logic [31:0] wait_cnt;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state    <= FFSUP_OFF;
			wait_cnt <= 32'h0000_0000;
		end else begin
			wait_cnt <= bump(wait_cnt, 1'b1);
			case (state)
				FFSUP_OFF: begin
					if (vdd_s) begin
						state    <= FFSUP_RUN;
						wait_cnt <= 32'h0000_0000;
					end
				end
				FFSUP_RUN: begin
					wait_cnt <= 32'h0000_0000;
					if (!vdd_s)
						state <= FFSUP_OFF;
					else if (f_latch)
						state <= FFSUP_LATCH;
					else if (f_lar)
						state <= FFSUP_LAR;
					else if (f_ar)
						state <= FFSUP_AR;
				end
				FFSUP_AR: begin
					if (wait_cnt >= 32'(AR_CYC) && vdd_s && !cmp.over_temp) begin
						state    <= FFSUP_RUN;
						wait_cnt <= 32'h0000_0000;
					end
				end
				FFSUP_LAR: begin
					if (wait_cnt >= 32'(LAR_CYC) && vdd_s) begin // [R19]
						state    <= FFSUP_RUN;
						wait_cnt <= 32'h0000_0000;
					end
				end
				FFSUP_LATCH: begin
					if (!vdd_s)
						state <= FFSUP_OFF; // [R21]
				end
				default: state <= FFSUP_OFF;
			endcase
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			switching_en     <= 1'b0;
			sd_startup_level <= 1'b1;
		end else begin
			switching_en     <= state == FFSUP_RUN;
			sd_startup_level <= state != FFSUP_RUN || uvp_blank; // [R08]
		end
	end

	// ****************************************************************
	// ahb-lite slave
	// ****************************************************************
	logic       wr_pend;
	logic [7:0] wr_addr;
	logic       clr_req;
	assign clr_req = wr_pend && wr_addr == `FFSUP_ADDR_CTRL && hwdata[`FFSUP_CTRL_CLR];
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			cause <= '0;
		else
			cause <= (clr_req ? '0 : cause) | (state == FFSUP_RUN ? next_cause : '0);
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend   <= 1'b0;
			wr_addr   <= 8'h00;
			ctrl      <= `FFSUP_CTRL_RESET;
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			if (wr_pend && wr_addr == `FFSUP_ADDR_CTRL)
				ctrl <= {29'h0000_0000, hwdata[2:0]};
			wr_pend <= 1'b0;
			if (hsel && hready && htrans[1]) begin
				wr_pend <= hwrite;
				wr_addr <= haddr[7:0];
				if (haddr[7:0] == `FFSUP_ADDR_CTRL)
					hrdata <= ctrl;
				else if (haddr[7:0] == `FFSUP_ADDR_STATUS)
					hrdata <= {24'h00_0000, brownin, uvp_blank, 3'b000, 3'(state)};
				else if (haddr[7:0] == `FFSUP_ADDR_CAUSE)
					hrdata <= {21'h00_0000, cause};
				else
					hrdata <= 32'h0000_0000;
			end
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	latch_hold_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R21]
		state == FFSUP_LATCH && vdd_s |=> state == FFSUP_LATCH)
		else $error("latch left while supply up");
	limit_kill_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R18]
		cmp.cs_above_limit |=> !gate_drive)
		else $error("gate on at current limit");
	otp_off_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R04]
		cmp.over_temp |=> !gate_drive)
		else $error("gate on in over temperature");
	ovp_trip_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R01]
		state == FFSUP_RUN && vdd_s && t_ovp > 32'(`FFSUP_VDD_OVP_CYC)
		|=> state != FFSUP_RUN)
		else $error("vdd overvoltage did not stop");
	olp_clear_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R17]
		!cmp.feedback_above_olp |=> t_olp == 32'h0000_0000)
		else $error("overload timer not cleared");
	uvp_blank_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R07]
		uvp_blank && state == FFSUP_RUN |=> $stable(n_uvp) || n_uvp == 8'h00)
		else $error("uvp counted during blanking");
	lar_hold_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R19]
		state == FFSUP_LAR && wait_cnt < 32'(LAR_CYC) |=> state == FFSUP_LAR)
		else $error("long restart ended early");
	sd_trip_a: assert property (@(posedge hclk) disable iff (!hresetn) // [R09] [R10]
		state == FFSUP_RUN && vdd_s && t_sd >= 32'(`FFSUP_SD_CYC)
		|=> state == FFSUP_AR || state == FFSUP_LATCH)
		else $error("shutdown not taken");
endmodule : ffsup_top
`default_nettype wire

// ### verification/ffsup_stage_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// power stage and sense network model
// ****
module ffsup_stage_model
	import ffsup_pkg::*;
(
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic       supply_up,
	input  wire ffsup_cmp_s fault_cmd,
	input  wire logic [3:0] hi_extra,
	output logic            gate_req,
	output logic            vdd_on,
	output var ffsup_cmp_s  cmp_in
);
	logic [4:0] phase;
	logic [4:0] hi_w;
	// pulse width picked once per period, 12 to 27 of 32 cycles
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase    <= 5'h00;
			hi_w     <= 5'h0c;
			gate_req <= 1'b0;
			vdd_on   <= 1'b0;
		end else begin
			vdd_on   <= supply_up;
			phase    <= phase + 5'h01;
			if (phase == 5'h00) begin
				hi_w <= 5'h0c + {1'b0, hi_extra};
			end
			gate_req <= supply_up & (phase < hi_w);
		end
	end
	// brown-in line sense and current sense only valid while the switch conducts
	always_comb begin
		cmp_in                = fault_cmd;
		cmp_in.line_above_bri = gate_req & ~fault_cmd.line_above_bri;
		cmp_in.cs_above_limit = gate_req & fault_cmd.cs_above_limit;
		cmp_in.cs_above_rectifier_short_guard  = gate_req & fault_cmd.cs_above_rectifier_short_guard;
		cmp_in.cs_below_cssp  = gate_req & fault_cmd.cs_below_cssp;
	end
endmodule : ffsup_stage_model
`default_nettype wire

// ### verification/tb_flyback_fault_supervisor.sv
`timescale 1ns/1ns
`default_nettype none
`include "ffsup_regs.svh"
module tb_flyback_fault_supervisor
	import ffsup_pkg::*;
;
	localparam int          LIMIT   = 60000;
	localparam logic [31:0] A_CTRL  = {24'h00_0000, `FFSUP_ADDR_CTRL};
	localparam logic [31:0] A_STAT  = {24'h00_0000, `FFSUP_ADDR_STATUS};
	localparam logic [31:0] A_CAUSE = {24'h00_0000, `FFSUP_ADDR_CAUSE};
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, note_rd;
	logic        gate_req, vdd_on, gate_drive, sd_startup_level, switching_en, supply_up;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [15:0] lfsr = 16'hA745;
	ffsup_cmp_s  cmp_in, fault_cmd;
	logic [63:0] expq[$];
	int          n_mismatch, checks, cyc;
	int          fbit[9] = '{10, 8, 7, 6, 5, 4, 3, 2, 1};
	logic [31:0] cfg[3]  = '{32'h0000_0001, 32'h0000_0002, 32'h0000_0004};
	int          lbit[3] = '{6, 4, 5};
	logic [2:0]  lst[3]  = '{FFSUP_LATCH, FFSUP_LATCH, FFSUP_LAR};
	ffsup_top #(
		.OLP_CYC                (200),
		.LAR_CYC                (300),
		.UVP_BNK_CYC            (1000),
		.AR_CYC                 (50),
		.brownin_debounce_count (4)
	) dut_u (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cmp_in(cmp_in),
		.vdd_on(vdd_on), .gate_req(gate_req), .gate_drive(gate_drive),
		.sd_startup_level(sd_startup_level), .switching_en(switching_en)
	);
	ffsup_stage_model model_u (
		.hclk(hclk), .hresetn(hresetn), .supply_up(supply_up), .fault_cmd(fault_cmd),
		.hi_extra(lfsr[3:0]), .gate_req(gate_req), .vdd_on(vdd_on), .cmp_in(cmp_in)
	);
	// ****
	// clock, random source, timeout
	// ****
	initial hclk = 1'b0;
	always #20 hclk = ~hclk;
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr_next
	always @(posedge hclk) begin
		lfsr <= lfsr_next(lfsr);
		cyc++;
		if (cyc == LIMIT) begin
			n_mismatch++;
			$display("ERROR %0t timeout", $time);
			tally_and_finish();
		end
	end
	// ****
	// compare and report
	// ****
	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
		checks++;
		if ((got & m) !== (exp & m)) begin
			n_mismatch++;
			$display("ERROR %0t read %h expected %h", $time, got, exp & m);
		end
	endtask : cmp_word
	task automatic cmp_pin(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t output %b expected %b", $time, got, exp);
		end
	endtask : cmp_pin
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : tally_and_finish
	always @(posedge hclk) begin : mon
		logic [63:0] e;
		if (note_rd === 1'b1 && hreadyout === 1'b1) begin
			e = expq.pop_front();
			cmp_word(hrdata, e[63:32], e[31:0]);
		end
	end
	// ****
	// bus master
	// ****
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
		input logic chk, output logic [31:0] rd);
		hsel    <= 1'b1;
		haddr   <= a;
		hwrite  <= w;
		htrans  <= 2'b10;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans  <= 2'b00;
		hwdata  <= wd;
		note_rd <= chk;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		note_rd <= 1'b0;
	endtask : bus
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, 1'b0, r);
	endtask : wr
	task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input logic [31:0] m);
		logic [31:0] r;
		expq.push_back({exp, m});
		bus(1'b0, a, 32'h0000_0000, 1'b1, r);
	endtask : rd_chk
	task automatic poll(input logic [2:0] st, input int bound);
		logic [31:0] r;
		int          k;
		k = 0;
		do begin
			bus(1'b0, A_STAT, 32'h0000_0000, 1'b0, r);
			k++;
		end while (r[2:0] !== st && k < bound);
		rd_chk(A_STAT, {29'h0000_0000, st}, 32'h0000_0007);
	endtask : poll
	// ****
	// main sequence
	// ****
	initial begin
		{hresetn, hsel, hwrite, htrans, note_rd, supply_up} = '0;
		{haddr, hwdata} = '0;
		hsize = 3'b010;
		fault_cmd = '0;
		n_mismatch = 0;
		checks = 0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		cmp_pin(sd_startup_level, 1'b1);
		cmp_pin(switching_en, 1'b0);
		cmp_pin(hresp, 1'b0);
		cmp_pin(hreadyout, 1'b1);
		rd_chk(A_CTRL, `FFSUP_CTRL_RESET, 32'hffff_ffff);
		rd_chk({24'h00_0000, lfsr[7:4] | 4'h1, lfsr[3:2], 2'b00}, 32'h0, 32'hffff_ffff);
		rd_chk(A_STAT, {29'h0, FFSUP_OFF}, 32'h0000_0007);
		supply_up <= 1'b1;
		poll(FFSUP_RUN, 400);
		repeat (160) @(posedge hclk);
		rd_chk(A_STAT, 32'h0000_00c0, 32'h0000_00c0);
		fault_cmd.output_sense_undervoltage <= 1'b1;
		repeat (600) @(posedge hclk);
		fault_cmd <= '0;
		repeat (500) @(posedge hclk);
		cmp_pin(sd_startup_level, 1'b0);
		rd_chk(A_STAT, {29'h0, FFSUP_RUN}, 32'h0000_0007);
		wait (gate_req === 1'b0);
		wait (gate_req === 1'b1);
		repeat (4) @(posedge hclk);
		cmp_pin(gate_drive, 1'b1);
		fault_cmd.cs_above_limit <= 1'b1;
		repeat (6) @(posedge hclk);
		cmp_pin(gate_drive, 1'b0);
		cmp_pin(gate_req, 1'b1);
		fault_cmd <= '0;
		for (int k = 0; k < 2; k++) begin
			fault_cmd.feedback_above_olp <= 1'b1;
			repeat (150) @(posedge hclk);
			fault_cmd <= '0;
			repeat (4) @(posedge hclk);
		end
		rd_chk(A_STAT, {29'h0, FFSUP_RUN}, 32'h0000_0007);
		rd_chk(A_CAUSE, 32'h0, 32'hffff_ffff);
		for (int i = 0; i < 9; i++) begin
			wr(A_CTRL, 32'h0000_0008);
			wr(A_CTRL, 32'h0000_0000);
			repeat (1100) @(posedge hclk);
			fault_cmd <= ffsup_cmp_s'(11'h001 << fbit[i]);
			poll(FFSUP_AR, 1500);
			cmp_pin(switching_en, 1'b0);
			cmp_pin(gate_drive, 1'b0);
			rd_chk(A_CAUSE, 32'h0000_0001 << i, 32'hffff_ffff);
			fault_cmd <= '0;
			poll(FFSUP_RUN, 1500);
		end
		for (int j = 0; j < 3; j++) begin
			wr(A_CTRL, cfg[j]);
			repeat (1100) @(posedge hclk);
			fault_cmd <= ffsup_cmp_s'(11'h001 << lbit[j]);
			poll(lst[j], 1500);
			fault_cmd <= '0;
			repeat (200) @(posedge hclk);
			rd_chk(A_STAT, {29'h0, lst[j]}, 32'h0000_0007);
			cmp_pin(gate_drive, 1'b0);
			if (lst[j] == FFSUP_LATCH) begin
				supply_up <= 1'b0;
				poll(FFSUP_OFF, 200);
				supply_up <= 1'b1;
			end
			poll(FFSUP_RUN, 1500);
		end
		wr(A_CTRL, 32'h0000_0000);
		supply_up <= 1'b0;
		poll(FFSUP_OFF, 200);
		wr(A_CTRL, 32'h0000_0008);
		fault_cmd.line_above_bri <= 1'b1;
		supply_up <= 1'b1;
		poll(FFSUP_AR, 1500);
		rd_chk(A_CAUSE, 32'h0000_0200, 32'hffff_ffff);
		tally_and_finish();
	end
endmodule : tb_flyback_fault_supervisor
`default_nettype wire
